// ==== fsc_defs.svh ====
// Constants for the frequency scan sequencer and its serial host
// Operation
// - Scan set by start, step, step count
// - Automatic or pin-driven external stepping modes
// - Auto interval counts clocks or output cycles
// - Auto mode: one trigger runs whole scan
// - External mode: each trigger rise steps once
// - Phase accumulator never reset between steps
// - Hold final frequency until reset
// - Scan lasts step count plus one intervals
// - One transfer is one 16-bit word
// - Frame select low enables serial input
// - One bit per falling serial clock
// - Select held low: each 16 bits a word
// - Host raises select after sixteenth falling edge
// - Serial clock may run free or idle
// - Host writes control first, then parameters
// - Control write resets scan, output midscale
// - Midscale holds until trigger starts scan
// - Address 0000 selects 12-bit control register
// - Address bits first, then data MSB first
// - Address decode of the seven registers
// - Abort pin rise resets scan to midscale
// - Trigger pin rise initialises and starts scan
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

`define FSC_WORD_BITS      16
`define FSC_DATA_BITS      12
`define FSC_FREQ_BITS      24
`define FSC_CNT_BITS       4
`define FSC_ADDR_MSB       15
`define FSC_ADDR_LSB       12

`define FSC_ADR_CONTROL    4'h0
`define FSC_ADR_STEP_COUNT 4'h1
`define FSC_ADR_STEP_LO    4'h2
`define FSC_ADR_STEP_HI    4'h3
`define FSC_ADR_INTERVAL   2'h1
`define FSC_ADR_START_LO   4'hC
`define FSC_ADR_START_HI   4'hD

`define FSC_CTRL_PAIRED    11
`define FSC_CTRL_EXT_STEP  5
`define FSC_INTV_BASE_BIT  13

`define FSC_RST_12         12'h000
`define FSC_RST_24         24'h00_0000
`define FSC_PIN_IDLE       5'h05

`define FSC_LINK_PERIOD_NS 80
`define FSC_CORE_PERIOD_NS 10
`define FSC_HALF_CYCLES    ((`FSC_LINK_PERIOD_NS / `FSC_CORE_PERIOD_NS) / 2)

`define FSC_HOST_ADR_TX    4'h0
`define FSC_HOST_ADR_PINS  4'h4
`define FSC_HOST_ADR_STAT  4'h8
`define FSC_HOST_PIN_TRIG  0
`define FSC_HOST_PIN_ABORT 1

`endif

// ==== fsc_pkg.sv ====
// Types shared by the frequency scan sequencer ends
package fsc_pkg;
   typedef enum logic [1:0] {FSC_IDLE, FSC_RUN, FSC_DONE} fsc_scan_t;
   typedef enum logic [2:0] {FSC_H_IDLE, FSC_H_SETUP, FSC_H_LOW, FSC_H_HIGH,
                             FSC_H_END} fsc_host_t;
endpackage : fsc_pkg

// ==== fsc_link_if.sv ====
// Serial configuration and control link between host and scan device
`timescale 1ns/1ns
interface fsc_link_if;
   logic serial_clk;
   logic serial_data_in;
   logic frame_select_n;
   logic scan_trigger;
   logic scan_abort;

   modport host (output serial_clk, output serial_data_in, output frame_select_n,
                 output scan_trigger, output scan_abort);
   modport dev  (input serial_clk, input serial_data_in, input frame_select_n,
                 input scan_trigger, input scan_abort);
endinterface : fsc_link_if

// ==== fsc_device.sv ====
// Scan device end: serial word receiver, registers, scan sequencer, phase accumulator
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "fsc_defs.svh"
module fsc_device (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_reset_n,
   fsc_link_if.dev                         link,
   output logic [`FSC_FREQ_BITS-1:0]       o_freq_word,
   output logic [`FSC_FREQ_BITS-1:0]       o_phase,
   output logic                            o_midscale,
   output logic                            o_step_pulse,
   output logic                            o_scan_done,
   output logic [`FSC_DATA_BITS-1:0]       o_mode_control
);
   localparam int NSYNC = 5;
   localparam logic [NSYNC-1:0] PIN_IDLE = `FSC_PIN_IDLE;

   logic [NSYNC-1:0]                 pins;
   logic [NSYNC-1:0]                 sync1_q;
   logic [NSYNC-1:0]                 sync2_q;
   logic [NSYNC-1:0]                 prev_q;
   logic                             sclk_fall;
   logic                             trig_rise;
   logic                             abort_rise;
   logic                             sel_low;
   logic [`FSC_WORD_BITS-1:0]        shift_q;
   logic [`FSC_CNT_BITS-1:0]         bit_cnt_q;
   logic                             word_ok;
   logic [`FSC_WORD_BITS-1:0]        word;
   logic [3:0]                       adr;
   logic [`FSC_DATA_BITS-1:0]        dat;
   logic [`FSC_DATA_BITS-1:0]        mode_control_q;
   logic [`FSC_DATA_BITS-1:0]        step_count_q;
   logic [`FSC_FREQ_BITS-1:0]        step_size_q;
   logic [`FSC_FREQ_BITS-1:0]        start_freq_q;
   logic [`FSC_DATA_BITS-1:0]        pend_lo_q;
   logic [`FSC_DATA_BITS-1:0]        interval_q;
   logic                             intv_cycles_q;
   logic                             ctrl_wr;
   logic                             scan_reset;
   fsc_pkg::fsc_scan_t               state_q;
   logic [`FSC_FREQ_BITS-1:0]        freq_q;
   logic [`FSC_FREQ_BITS-1:0]        phase_q;
   logic [`FSC_FREQ_BITS-1:0]        phase_d;
   logic [`FSC_DATA_BITS-1:0]        steps_q;
   logic [`FSC_DATA_BITS-1:0]        tick_cnt_q;
   logic                             tick;
   logic                             interval_end;
   logic                             midscale_q;
   logic                             step_pulse_q;
   logic                             done_q;

   // Every link pin crosses by two flip-flops before use
   assign pins = {link.scan_abort, link.scan_trigger, link.frame_select_n,
                  link.serial_data_in, link.serial_clk};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge i_core_clk) begin
            // Idle levels at reset, so no false edge or select follows it
            if (!i_reset_n) begin
               sync1_q[g] <= PIN_IDLE[g];
               sync2_q[g] <= PIN_IDLE[g];
               prev_q[g]  <= PIN_IDLE[g];
            end else begin
               sync1_q[g] <= pins[g];
               sync2_q[g] <= sync1_q[g];
               prev_q[g]  <= sync2_q[g];
            end
         end
      end
   endgenerate

   assign sclk_fall  = prev_q[0] & ~sync2_q[0];
   assign sel_low    = ~sync2_q[2];
   assign trig_rise  = ~prev_q[3] & sync2_q[3];
   assign abort_rise = ~prev_q[4] & sync2_q[4];

   // Edge detection alone makes the receiver indifferent to clock idle level
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         shift_q   <= 16'h0000;
         bit_cnt_q <= 4'h0;
      end else if (!sel_low) begin
         bit_cnt_q <= 4'h0;
      end else if (sclk_fall) begin
         shift_q   <= {shift_q[`FSC_WORD_BITS-2:0], sync2_q[1]};
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   assign word_ok = sel_low & sclk_fall & (bit_cnt_q == 4'hF);
   assign word    = {shift_q[`FSC_WORD_BITS-2:0], sync2_q[1]};
   assign adr     = word[`FSC_ADDR_MSB:`FSC_ADDR_LSB];
   assign dat     = word[`FSC_DATA_BITS-1:0];
   assign ctrl_wr = word_ok & (adr == `FSC_ADR_CONTROL);

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         mode_control_q <= `FSC_RST_12;
      end else if (ctrl_wr) begin
         mode_control_q <= dat;
      end
   end

   // Paired mode holds the low half so the register never shows a mixed value
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         step_count_q  <= `FSC_RST_12;
         step_size_q   <= `FSC_RST_24;
         start_freq_q  <= `FSC_RST_24;
         pend_lo_q     <= `FSC_RST_12;
         interval_q    <= `FSC_RST_12;
         intv_cycles_q <= 1'b0;
      end else if (word_ok) begin
         if (adr[3:2] == `FSC_ADR_INTERVAL) begin
            interval_q    <= dat;
            intv_cycles_q <= word[`FSC_INTV_BASE_BIT];
         end else begin
            unique case (adr)
               `FSC_ADR_STEP_COUNT: step_count_q <= dat;
               `FSC_ADR_STEP_LO, `FSC_ADR_START_LO: begin
                  if (mode_control_q[`FSC_CTRL_PAIRED]) begin
                     pend_lo_q <= dat;
                  end else if (adr == `FSC_ADR_STEP_LO) begin
                     step_size_q[`FSC_DATA_BITS-1:0] <= dat;
                  end else begin
                     start_freq_q[`FSC_DATA_BITS-1:0] <= dat;
                  end
               end
               `FSC_ADR_STEP_HI: begin
                  step_size_q[`FSC_FREQ_BITS-1:`FSC_DATA_BITS] <= dat;
                  if (mode_control_q[`FSC_CTRL_PAIRED]) begin
                     step_size_q[`FSC_DATA_BITS-1:0] <= pend_lo_q;
                  end
               end
               `FSC_ADR_START_HI: begin
                  start_freq_q[`FSC_FREQ_BITS-1:`FSC_DATA_BITS] <= dat;
                  if (mode_control_q[`FSC_CTRL_PAIRED]) begin
                     start_freq_q[`FSC_DATA_BITS-1:0] <= pend_lo_q;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign scan_reset = ctrl_wr | abort_rise;

   // Output-cycle base ticks on each wrap of the phase accumulator
   assign phase_d = phase_q + freq_q;
   assign tick    = intv_cycles_q ? (phase_d < phase_q) : 1'b1;
   assign interval_end = (state_q == fsc_pkg::FSC_RUN) &&
      (mode_control_q[`FSC_CTRL_EXT_STEP] ? trig_rise
       : (tick && (tick_cnt_q + 12'h001 >= interval_q)));

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         tick_cnt_q <= 12'h000;
      end else if (scan_reset || state_q != fsc_pkg::FSC_RUN || interval_end) begin
         tick_cnt_q <= 12'h000;
      end else if (tick) begin
         tick_cnt_q <= tick_cnt_q + 12'h001;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state_q <= fsc_pkg::FSC_IDLE;
         freq_q  <= `FSC_RST_24;
         steps_q <= 12'h000;
      end else if (scan_reset) begin
         state_q <= fsc_pkg::FSC_IDLE;
         freq_q  <= `FSC_RST_24;
         steps_q <= 12'h000;
      end else begin
         unique case (state_q)
            fsc_pkg::FSC_IDLE: begin
               if (trig_rise) begin
                  state_q <= fsc_pkg::FSC_RUN;
                  freq_q  <= start_freq_q;
                  steps_q <= 12'h000;
               end
            end
            fsc_pkg::FSC_RUN: begin
               if (interval_end) begin
                  if (steps_q == step_count_q) begin
                     state_q <= fsc_pkg::FSC_DONE;
                  end else begin
                     freq_q  <= freq_q + step_size_q;
                     steps_q <= steps_q + 12'h001;
                  end
               end
            end
            fsc_pkg::FSC_DONE: begin
               state_q <= fsc_pkg::FSC_DONE;
            end
         endcase
      end
   end

   // Accumulator keeps running across steps, cleared only by scan reset or idle
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         phase_q <= `FSC_RST_24;
      end else if (scan_reset || state_q == fsc_pkg::FSC_IDLE) begin
         phase_q <= `FSC_RST_24;
      end else begin
         phase_q <= phase_d;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         midscale_q   <= 1'b1;
         step_pulse_q <= 1'b0;
         done_q       <= 1'b0;
      end else begin
         midscale_q   <= scan_reset | (state_q == fsc_pkg::FSC_IDLE & ~trig_rise);
         step_pulse_q <= interval_end & (steps_q != step_count_q) & ~scan_reset;
         done_q       <= ~scan_reset & (state_q == fsc_pkg::FSC_DONE |
                         (interval_end & steps_q == step_count_q));
      end
   end

   assign o_freq_word    = freq_q;
   assign o_phase        = phase_q;
   assign o_midscale     = midscale_q;
   assign o_step_pulse   = step_pulse_q;
   assign o_scan_done    = done_q;
   assign o_mode_control = mode_control_q;
endmodule : fsc_device

// ==== fsc_host.sv ====
// Host end: register port driven serial word writer and scan pin control
`timescale 1ns/1ns
`include "fsc_defs.svh"
module fsc_host (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_reset_n,
   input  wire logic [3:0]            i_addr,
   input  wire logic [15:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic [15:0]                o_rdata,
   fsc_link_if.host                   link
);
   fsc_pkg::fsc_host_t  state_q;
   logic [15:0]         word_q;
   logic [3:0]          bits_q;
   logic [2:0]          div_q;
   logic                div_end;
   logic                sclk_q;
   logic                sel_n_q;
   logic                trig_q;
   logic                abort_q;
   logic [15:0]         rdata_q;
   logic                busy;

   assign busy    = (state_q != fsc_pkg::FSC_H_IDLE);
   assign div_end = (div_q == 3'(`FSC_HALF_CYCLES - 1));

   // Link clock is this end's own clock divided; idles high between words
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state_q <= fsc_pkg::FSC_H_IDLE;
         word_q  <= 16'h0000;
         bits_q  <= 4'h0;
         div_q   <= 3'h0;
         sclk_q  <= 1'b1;
         sel_n_q <= 1'b1;
      end else begin
         div_q <= (state_q == fsc_pkg::FSC_H_IDLE || div_end) ? 3'h0 : div_q + 3'h1;
         unique case (state_q)
            fsc_pkg::FSC_H_IDLE: begin
               if (i_wr && i_addr == `FSC_HOST_ADR_TX) begin
                  word_q  <= i_wdata;
                  bits_q  <= 4'h0;
                  sel_n_q <= 1'b0;
                  state_q <= fsc_pkg::FSC_H_SETUP;
               end
            end
            fsc_pkg::FSC_H_SETUP, fsc_pkg::FSC_H_HIGH: begin
               if (div_end) begin
                  sclk_q  <= 1'b0;
                  state_q <= fsc_pkg::FSC_H_LOW;
               end
            end
            fsc_pkg::FSC_H_LOW: begin
               if (div_end) begin
                  sclk_q <= 1'b1;
                  word_q <= {word_q[14:0], 1'b0};
                  bits_q <= bits_q + 4'h1;
                  state_q <= (bits_q == 4'hF) ? fsc_pkg::FSC_H_END : fsc_pkg::FSC_H_HIGH;
               end
            end
            fsc_pkg::FSC_H_END: begin
               if (div_end) begin
                  sel_n_q <= 1'b1;
                  state_q <= fsc_pkg::FSC_H_IDLE;
               end
            end
            default: begin
               state_q <= fsc_pkg::FSC_H_IDLE;
            end
         endcase
      end
   end

   // Pins are levels; software makes the rising edges that start or step
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         trig_q  <= 1'b0;
         abort_q <= 1'b0;
      end else if (i_wr && i_addr == `FSC_HOST_ADR_PINS) begin
         trig_q  <= i_wdata[`FSC_HOST_PIN_TRIG];
         abort_q <= i_wdata[`FSC_HOST_PIN_ABORT];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         rdata_q <= 16'h0000;
      end else if (i_rd) begin
         unique case (i_addr)
            `FSC_HOST_ADR_PINS: rdata_q <= {14'h0000, abort_q, trig_q};
            `FSC_HOST_ADR_STAT: rdata_q <= {15'h0000, busy};
            default:            rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign o_rdata             = rdata_q;
   assign link.serial_clk     = sclk_q;
   assign link.serial_data_in = word_q[15];
   assign link.frame_select_n = sel_n_q;
   assign link.scan_trigger   = trig_q;
   assign link.scan_abort     = abort_q;
endmodule : fsc_host

// ==== fsc_link_chk.sv ====
// Framing checks on the serial link between host and scan device
`timescale 1ns/1ns
module fsc_link_chk (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic frame_select_n,
   input wire logic scan_trigger,
   input wire logic scan_abort
);
   logic [4:0] falls_q;

   // Falls seen in the current frame; cleared while deselected
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || frame_select_n) begin
         falls_q <= 5'h00;
      end else if ($fell(serial_clk)) begin
         falls_q <= falls_q + 5'h01;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   sclk_idle_a: assert property (frame_select_n |-> serial_clk)
      else $error("serial clock not idle high outside frame");
   fall_sel_a: assert property ($fell(serial_clk) |-> !frame_select_n)
      else $error("serial clock fell while deselected");
   data_hold_a: assert property (!serial_clk |-> $stable(serial_data_in))
      else $error("serial data moved while clock low");
   low_phase_a: assert property ($fell(serial_clk) |-> !serial_clk [*4] ##1 serial_clk)
      else $error("serial clock low phase not four cycles");
   high_phase_a: assert property ($rose(serial_clk) |->
      serial_clk [*4] ##1 (frame_select_n || !serial_clk))
      else $error("serial clock high phase not four cycles");
   sel_setup_a: assert property ($fell(frame_select_n) |-> serial_clk [*4] ##1 !serial_clk)
      else $error("first fall not four cycles after select");
   word_len_a: assert property ($rose(frame_select_n) |-> falls_q == 5'h10)
      else $error("frame did not carry sixteen falls");
   frame_len_a: assert property ($fell(frame_select_n) |-> ##132 $rose(frame_select_n))
      else $error("frame length wrong");

   cover property ($rose(frame_select_n));
   cover property ($rose(scan_trigger));
   cover property ($rose(scan_abort));
endmodule : fsc_link_chk

// ==== frequency_scan_sequencer_bench.sv ====
// Bench: host and scan device joined over the serial link
`timescale 1ns/1ns
module frequency_scan_sequencer_bench;
   logic        i_core_clk = 1'b0;
   logic        i_reset_n  = 1'b0;
   logic [3:0]  i_addr     = 4'h0;
   logic [15:0] i_wdata    = 16'h0000;
   logic        i_wr       = 1'b0;
   logic        i_rd       = 1'b0;
   logic [15:0] o_rdata;
   logic [23:0] o_freq_word;
   logic [23:0] o_phase;
   logic        o_midscale;
   logic        o_step_pulse;
   logic        o_scan_done;
   logic [11:0] o_mode_control;
   logic [23:0] st;
   logic [23:0] stp;
   logic [23:0] p;
   logic [15:0] cap;
   logic [15:0] d;
   logic [3:0]  n;
   logic        sp = 1'b0;
   int          n_fail = 0;
   int          compares = 0;
   int          steps = 0;
   int          w;
   int          k;
   int          t0;

   fsc_link_if link ();
   fsc_host fsc_host_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link));
   fsc_device fsc_device_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link),
      .o_freq_word(o_freq_word), .o_phase(o_phase), .o_midscale(o_midscale),
      .o_step_pulse(o_step_pulse), .o_scan_done(o_scan_done), .o_mode_control(o_mode_control));
   fsc_link_chk fsc_link_chk_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .serial_clk(link.serial_clk), .serial_data_in(link.serial_data_in),
      .frame_select_n(link.frame_select_n), .scan_trigger(link.scan_trigger),
      .scan_abort(link.scan_abort));

   always #5 i_core_clk = ~i_core_clk;

   // Bits as the device should see them
   always @(negedge link.serial_clk) begin
      if (!link.frame_select_n) cap = {cap[14:0], link.serial_data_in};
   end

   // Frequency checked a cycle after each step pulse; falling edge keeps clear of updates
   always @(negedge i_core_clk) begin
      if (sp) chk(o_freq_word, ex(4'(steps)));
      sp = (o_step_pulse === 1'b1);
      if (sp) steps++;
   end

   function automatic logic [23:0] ex(input logic [3:0] m);
      return st + stp * m;
   endfunction : ex

   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   task automatic send(input logic [15:0] v);
      wr(4'h0, v);
      w = 0;
      do begin
         rd(4'h8);
         w++;
      end while (d[0] !== 1'b0 && w < 100);
      chk(24'(d[0]), 24'h00_0000);
      chk(24'(cap), 24'(v));
   endtask : send

   task automatic pulse(input logic [15:0] v);
      wr(4'h4, v);
      repeat (4) @(posedge i_core_clk);
      wr(4'h4, 16'h0000);
      repeat (6) @(posedge i_core_clk);
   endtask : pulse

   task automatic run(input logic [11:0] ctl, input logic base);
      logic [11:0] ivl;
      ivl = 12'($urandom_range(6, 3));
      n   = 4'($urandom_range(3, 1));
      st  = {12'($urandom_range(2047, 256)), 12'($urandom)};
      // No wrap past the top, so output-cycle intervals stay short
      stp = {4'h0, 20'($urandom)};
      send({4'h0, ctl});
      chk(24'(o_mode_control), 24'(ctl));
      chk(24'(o_midscale), 24'h00_0001);
      chk(o_freq_word, 24'h00_0000);
      chk(24'(o_scan_done), 24'h00_0000);
      send({4'h1, 8'h00, n});
      send({4'h2, stp[11:0]});
      send({4'h3, stp[23:12]});
      send({2'b01, base, 1'b0, ivl});
      send({4'hC, st[11:0]});
      send({4'hD, st[23:12]});
      send({4'hE, 12'hfff});
      send({4'h8, 12'hfff});
      chk(24'(o_midscale), 24'h00_0001);
      steps = 0;
      wr(4'h4, 16'h0001);
      w = 0;
      while (o_midscale !== 1'b0 && w < 20) begin
         @(posedge i_core_clk);
         #1 w = w + 1;
      end
      t0 = $time;
      chk(o_freq_word, ex(4'h0));
      wr(4'h4, 16'h0000);
      repeat (4) @(posedge i_core_clk);
      if (ctl[5]) begin
         for (k = 0; k <= n; k++) pulse(16'h0001);
         chk(24'(o_scan_done), 24'h00_0001);
      end else begin
         w = 0;
         while (o_scan_done !== 1'b1 && w < 3000) begin
            @(posedge i_core_clk);
            #1 w = w + 1;
         end
         chk(24'(o_scan_done), 24'h00_0001);
         // Detection latency differs at start and end, so allow a small slack
         if (!base) chk(24'(($time - t0) / 10 + 3 - (n + 1) * ivl < 7), 24'h00_0001);
      end
      chk(24'(steps), 24'(n));
      chk(o_freq_word, ex(n));
      #1 p = o_phase;
      @(posedge i_core_clk);
      #1 chk(o_phase, p + ex(n));
      pulse(16'h0001);
      chk(o_freq_word, ex(n));
      pulse(16'h0002);
      chk(24'(o_midscale), 24'h00_0001);
      chk(o_freq_word, 24'h00_0000);
      // Leave a scan started, so the next control write must reset it
      steps = 0;
      pulse(16'h0001);
      chk(24'(o_midscale), 24'h00_0000);
      repeat (30) @(posedge i_core_clk);
   endtask : run

   task automatic give_verdict();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      void'($urandom(12));
      repeat (5) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      rd(4'h8);
      chk(24'(d), 24'h00_0000);
      chk(24'(o_midscale), 24'h00_0001);
      run(12'h000, 1'b0);
      run(12'h020, 1'b0);
      run(12'h800, 1'b1);
      give_verdict();
   end

   // Three runs take roughly a tenth of this
   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end
endmodule : frequency_scan_sequencer_bench
